// [logic/relay_regs.svh]
/*
 * Register offsets, feature command codes, reset values and timing counts
 * for the USB relay report interpreter.
 * Assumes byte addresses on a 32-bit Avalon-MM bus, one aligned word per register.
 */
`ifndef RELAY_REGS_SVH
`define RELAY_REGS_SVH

// Register byte offsets.
`define OFS_OUT_REPORT   8'h00
`define OFS_IN_FRAME     8'h04
`define OFS_IN_STATES    8'h08
`define OFS_STATUS       8'h0c
`define OFS_FEAT_CTRL    8'h10
`define OFS_FEAT_BUF     8'h20
`define OFS_FEAT_END     8'h3c

// Status register bit positions.
`define STAT_PENDING     0
`define STAT_STANDBY     1
`define STAT_FEAT_ERR    2
`define STAT_RELAY_LSB   8

// Feature report layout.
`define FEAT_BYTES       32
`define LABEL_FIRST      5
`define LABEL_BYTES      21
`define LABEL_COUNT      6
`define FEAT_SET         8'h00
`define FEAT_GET         8'h01
`define TGT_RAM          8'h00
`define TGT_FLASH        8'h01
`define FC_MODE          8'h01
`define FC_RATE          8'h02
`define FC_LABEL         8'h15
`define SUB_REPORT_MODE  8'h00
`define SUB_LED_MODE     8'h01
`define SUB_IN_INTERVAL  8'h00
`define SUB_SAMPLE       8'h01
`define SUB_LABEL_MAX    8'h05

// Reset values and interval limits, in milliseconds.
`define DEF_IN_INTERVAL  16'h0064
`define DEF_SAMPLE       16'h000a
`define MIN_IN_INTERVAL  16'h0001
`define MIN_SAMPLE       16'h0004

// Timing.
`define CLK_PERIOD_NS    5
`define MS_PERIOD_NS     1000000
`define CYC_PER_MS       (`MS_PERIOD_NS / `CLK_PERIOD_NS)
`define LED_STEP_MS      100
`define LED_STEPS        10

`endif

// [logic/relay_pkg.sv]
/*
 * Types for the USB relay report interpreter.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package relay_pkg;

    typedef enum logic [1:0] {
        TRIG_AFTER_SAMPLE = 2'b00,
        TRIG_ON_CHANGE    = 2'b01,
        TRIG_FIXED_RATE   = 2'b10
    } report_trigger_t;

    typedef enum logic [2:0] {
        LED_OFF   = 3'b000,
        LED_ON    = 3'b001,
        LED_SLOW  = 3'b010,
        LED_FAST  = 3'b011,
        LED_BURST = 3'b100
    } light_mode_t;

    typedef struct packed {
        report_trigger_t report_trigger_mode;
        light_mode_t     indicator_light_mode;
        logic [15:0]     in_report_interval;
        logic [15:0]     state_sampling_interval;
    } cfg_t;

endpackage : relay_pkg

// [logic/usb_relay_report_interpreter.sv]
/*
 * Report interpreter of a four-channel relay card: OUT and IN reports,
 * feature configuration, millisecond timebase and indicator light.
 * Assumes endpoint firmware moves reports over the Avalon-MM slave
 * and drives usb_suspend high while the bus is suspended.
 */
// How it works
// RQ1 - OUT report byte k commands relay k.
// RQ2 - Low nibble applies in normal operation, high nibble in standby.
// RQ3 - Nibble 0 off, 1 on, 2 toggle, 3 to 15 hold.
// RQ4 - IN report: 16-bit ms frame number, then four state bytes.
// RQ5 - Each state byte reads 0 for off and 1 for on.
// RQ6 - Feature reports are 32 bytes in a buffer of their own.
// RQ7 - Feature byte 0: 0 sets, 1 reads back.
// RQ8 - Feature byte 1: 0 working copy, 1 persistent copy.
// RQ9 - Code 01 00 00 sets report trigger; fixed rate is default.
// RQ10 - Code 01 01 sets light mode: off, on, slow, fast, four-pulse bursts.
// RQ11 - Code 02 00 sets IN report interval, low byte first, fixed mode only.
// RQ12 - Code 02 01 sets sampling interval in ms, low byte first.
// RQ13 - Trigger mode 0 sends an IN report at every sample.
// RQ14 - Code 15 00 carries the device label in bytes 5 to 25.
// RQ15 - Code 15 with selector 1 to 5 carries channel labels.
// RQ16 - Relay command applied within one millisecond.
// RQ17 - IN report interval accepted from 1 ms to 65535 ms.
// RQ18 - Sampling interval accepted from 4 ms to 65535 ms.
// RQ19 - Entering standby applies each relay's standby nibble.
// RQ20 - Host should set relays off in standby.
// RQ21 - A get echoes bytes 0 to 4 and fills in the value.
`timescale 1ns/1ps
`include "relay_regs.svh"

module usb_relay_report_interpreter
    import relay_pkg::*;
#(
    parameter int CYC_PER_MS = `CYC_PER_MS
) (
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // Avalon-MM slave.
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // Bus power state.
    input  wire logic        usb_suspend,
    // Outputs.
    output logic      [3:0]  relay_on,
    output logic             indicator_light,
    output logic             report_strobe
);

    localparam int MSW = (CYC_PER_MS > 1) ? $clog2(CYC_PER_MS) : 1;
    localparam logic [MSW-1:0] MS_LAST = MSW'(CYC_PER_MS - 1);

    if (CYC_PER_MS < 2) begin : g_bad_rate
        $error("CYC_PER_MS must be at least 2");
    end

    logic [7:0]     out_cmd [4];
    logic [7:0]     feat_buf [`FEAT_BYTES];
    logic [7:0]     label [2][`LABEL_COUNT][`LABEL_BYTES];
    cfg_t           cfg [2];
    logic           feat_error;
    logic           suspend_q;
    logic [MSW-1:0] ms_cnt;
    logic           ms_tick;
    logic [15:0]    frame;
    logic [15:0]    samp_cnt;
    logic           sample_tick;
    logic [3:0]     sampled;
    logic [15:0]    rpt_cnt;
    logic           rpt_tick;
    logic [15:0]    in_frame;
    logic [3:0]     in_state;
    logic           report_pending;
    logic [6:0]     led_ms;
    logic [3:0]     led_step;

    wire acc_wr   = avs_write && !avs_waitrequest;
    wire acc_rd   = avs_read && !avs_waitrequest;
    wire out_wr   = acc_wr && avs_address == `OFS_OUT_REPORT;
    wire feat_go  = acc_wr && avs_address == `OFS_FEAT_CTRL && avs_writedata[0];
    wire entering = usb_suspend && !suspend_q;
    wire [5:0] buf_word = avs_address[7:2] - 6'(`OFS_FEAT_BUF >> 2);

    // Applies one nibble command to a relay's present state.
    function automatic logic apply_nibble(input logic [3:0] cmd, input logic cur);
        if (cmd == 4'h0) begin
            return 1'b0;
        end else if (cmd == 4'h1) begin
            return 1'b1;
        end else if (cmd == 4'h2) begin
            return !cur;
        end else begin
            return cur;
        end
    endfunction : apply_nibble

    // Clamps an interval to its least legal value.
    function automatic logic [15:0] clamp_min(input logic [15:0] v, input logic [15:0] lo);
        return (v < lo) ? lo : v;
    endfunction : clamp_min

    // One wait state on every access.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            avs_waitrequest <= 1'b1;
        end else if ((avs_read || avs_write) && avs_waitrequest) begin
            avs_waitrequest <= 1'b0;
        end else begin
            avs_waitrequest <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            avs_readdata <= 32'h0;
        end else if (avs_read && avs_waitrequest) begin
            if (avs_address == `OFS_OUT_REPORT) begin
                avs_readdata <= {out_cmd[3], out_cmd[2], out_cmd[1], out_cmd[0]};
            end else if (avs_address == `OFS_IN_FRAME) begin
                avs_readdata <= {16'h0, in_frame};                                //RQ4
            end else if (avs_address == `OFS_IN_STATES) begin
                avs_readdata <= {7'h0, in_state[3], 7'h0, in_state[2],
                                 7'h0, in_state[1], 7'h0, in_state[0]};             //RQ5
            end else if (avs_address == `OFS_STATUS) begin
                avs_readdata <= {20'h0, relay_on, 5'h0, feat_error, suspend_q,
                                 report_pending};
            end else if (avs_address >= `OFS_FEAT_BUF && avs_address <= `OFS_FEAT_END) begin
                avs_readdata <= {feat_buf[{buf_word[2:0], 2'd3}],
                                 feat_buf[{buf_word[2:0], 2'd2}],
                                 feat_buf[{buf_word[2:0], 2'd1}],
                                 feat_buf[{buf_word[2:0], 2'd0}]};                  //RQ6
            end else begin
                avs_readdata <= 32'h0;
            end
        end
    end

    // Relay commands and standby entry.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            suspend_q <= 1'b0;
            relay_on  <= 4'h0;
            for (int k = 0; k < 4; k++) begin
                out_cmd[k] <= 8'h0;
            end
        end else begin
            suspend_q <= usb_suspend;
            for (int k = 0; k < 4; k++) begin
                logic [7:0] cmd;
                cmd = (out_wr && avs_byteenable[k]) ? avs_writedata[8*k +: 8] : out_cmd[k];  //RQ1
                if (out_wr && avs_byteenable[k]) begin
                    out_cmd[k] <= cmd;
                end
                if ((out_wr && avs_byteenable[k]) || entering) begin                 //RQ16
                    relay_on[k] <= apply_nibble(usb_suspend ? cmd[7:4] : cmd[3:0],
                                                relay_on[k]);                        //RQ2 RQ3 RQ19
                end
            end
        end
    end

    // Feature buffer, configuration copies and labels.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            feat_error <= 1'b0;
            for (int t = 0; t < 2; t++) begin
                cfg[t] <= '{TRIG_FIXED_RATE, LED_OFF, `DEF_IN_INTERVAL, `DEF_SAMPLE}; //RQ9 RQ10
                for (int c = 0; c < `LABEL_COUNT; c++) begin
                    for (int i = 0; i < `LABEL_BYTES; i++) begin
                        label[t][c][i] <= 8'h0;
                    end
                end
            end
            for (int i = 0; i < `FEAT_BYTES; i++) begin
                feat_buf[i] <= 8'h0;
            end
        end else if (acc_wr && avs_address >= `OFS_FEAT_BUF && avs_address <= `OFS_FEAT_END) begin
            for (int b = 0; b < 4; b++) begin
                if (avs_byteenable[b]) begin
                    feat_buf[{buf_word[2:0], 2'(b)}] <= avs_writedata[8*b +: 8];
                end
            end
        end else if (feat_go) begin
            logic       get;
            logic       tgt;
            logic [2:0] ch;
            logic [15:0] val;
            get = feat_buf[0] == `FEAT_GET;                                           //RQ7
            tgt = feat_buf[1] == `TGT_FLASH;                                          //RQ8
            ch  = feat_buf[3][2:0];
            val = {feat_buf[6], feat_buf[5]};
            feat_error <= 1'b0;
            if ((feat_buf[0] != `FEAT_SET && !get) || (feat_buf[1] != `TGT_RAM && !tgt)
                || feat_buf[4] != 8'h0) begin
                feat_error <= 1'b1;
            end else if (feat_buf[2] == `FC_MODE && feat_buf[3] == `SUB_REPORT_MODE) begin
                if (get) begin
                    feat_buf[5] <= {6'h0, cfg[tgt].report_trigger_mode};             //RQ21
                end else if (feat_buf[5] <= 8'h2) begin
                    cfg[tgt].report_trigger_mode <= report_trigger_t'(feat_buf[5][1:0]); //RQ9
                end else begin
                    feat_error <= 1'b1;
                end
            end else if (feat_buf[2] == `FC_MODE && feat_buf[3] == `SUB_LED_MODE) begin
                if (get) begin
                    feat_buf[5] <= {5'h0, cfg[tgt].indicator_light_mode};
                end else if (feat_buf[5] <= 8'h4) begin
                    cfg[tgt].indicator_light_mode <= light_mode_t'(feat_buf[5][2:0]); //RQ10
                end else begin
                    feat_error <= 1'b1;
                end
            end else if (feat_buf[2] == `FC_RATE && feat_buf[3] == `SUB_IN_INTERVAL) begin
                if (get) begin
                    {feat_buf[6], feat_buf[5]} <= cfg[tgt].in_report_interval;
                end else begin
                    cfg[tgt].in_report_interval <= clamp_min(val, `MIN_IN_INTERVAL); //RQ11 RQ17
                end
            end else if (feat_buf[2] == `FC_RATE && feat_buf[3] == `SUB_SAMPLE) begin
                if (get) begin
                    {feat_buf[6], feat_buf[5]} <= cfg[tgt].state_sampling_interval;
                end else begin
                    cfg[tgt].state_sampling_interval <= clamp_min(val, `MIN_SAMPLE); //RQ12 RQ18
                end
            end else if (feat_buf[2] == `FC_LABEL && feat_buf[3] <= `SUB_LABEL_MAX) begin
                for (int i = 0; i < `LABEL_BYTES; i++) begin
                    if (get) begin
                        feat_buf[`LABEL_FIRST + i] <= label[tgt][ch][i];
                    end else begin
                        label[tgt][ch][i] <= feat_buf[`LABEL_FIRST + i];              //RQ14 RQ15
                    end
                end
            end else begin
                feat_error <= 1'b1;
            end
        end
    end

    // Millisecond timebase and frame number.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ms_cnt  <= '0;
            ms_tick <= 1'b0;
            frame   <= 16'h0;
        end else if (ms_cnt == MS_LAST) begin
            ms_cnt  <= '0;
            ms_tick <= 1'b1;
            frame   <= frame + 16'h1;                                                 //RQ4
        end else begin
            ms_cnt  <= ms_cnt + 1'b1;
            ms_tick <= 1'b0;
        end
    end

    // Relay state sampling and fixed-rate report timing, both in working copy units.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            samp_cnt    <= 16'h0;
            sample_tick <= 1'b0;
            sampled     <= 4'h0;
            rpt_cnt     <= 16'h0;
            rpt_tick    <= 1'b0;
        end else begin
            sample_tick <= 1'b0;
            rpt_tick    <= 1'b0;
            if (ms_tick) begin
                if (samp_cnt >= cfg[0].state_sampling_interval - 16'h1) begin
                    samp_cnt    <= 16'h0;
                    sample_tick <= 1'b1;
                    sampled     <= relay_on;
                end else begin
                    samp_cnt <= samp_cnt + 16'h1;
                end
                if (rpt_cnt >= cfg[0].in_report_interval - 16'h1) begin
                    rpt_cnt  <= 16'h0;
                    rpt_tick <= 1'b1;
                end else begin
                    rpt_cnt <= rpt_cnt + 16'h1;
                end
            end
        end
    end

    // IN report snapshot; a new report beats a clearing read.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            in_frame       <= 16'h0;
            in_state       <= 4'h0;
            report_pending <= 1'b0;
            report_strobe  <= 1'b0;
        end else begin
            logic fire;
            fire = (cfg[0].report_trigger_mode == TRIG_AFTER_SAMPLE && sample_tick)   //RQ13
                || (cfg[0].report_trigger_mode == TRIG_ON_CHANGE && sample_tick
                    && sampled != in_state)
                || (cfg[0].report_trigger_mode == TRIG_FIXED_RATE && rpt_tick);        //RQ11
            report_strobe <= fire;
            if (fire) begin
                in_frame       <= frame;
                in_state       <= sampled;
                report_pending <= 1'b1;
            end else if (acc_rd && avs_address == `OFS_IN_STATES) begin
                report_pending <= 1'b0;
            end
        end
    end

    // Indicator light: 100 ms steps over a one second cycle.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            led_ms          <= 7'h0;
            led_step        <= 4'h0;
            indicator_light <= 1'b0;
        end else begin
            if (ms_tick) begin
                if (led_ms == 7'(`LED_STEP_MS - 1)) begin
                    led_ms   <= 7'h0;
                    led_step <= (led_step == 4'(`LED_STEPS - 1)) ? 4'h0 : led_step + 4'h1;
                end else begin
                    led_ms <= led_ms + 7'h1;
                end
            end
            case (cfg[0].indicator_light_mode)
                LED_ON:    indicator_light <= 1'b1;
                LED_SLOW:  indicator_light <= led_step < 4'h5;
                LED_FAST:  indicator_light <= !led_step[0];
                LED_BURST: indicator_light <= led_step < 4'h8 && !led_step[0];        //RQ10
                default:   indicator_light <= 1'b0;
            endcase
        end
    end

    a_normal_on: assert property (@(posedge clk) disable iff (sys_rst)          //RQ2
        out_wr && avs_byteenable[0] && !usb_suspend && avs_writedata[3:0] == 4'h1
        |=> relay_on[0])
        else $error("nibble 1 did not switch relay 0 on");

    a_toggle_cmd: assert property (@(posedge clk) disable iff (sys_rst)         //RQ3
        out_wr && avs_byteenable[1] && !usb_suspend && avs_writedata[11:8] == 4'h2
        |=> relay_on[1] != $past(relay_on[1]))
        else $error("toggle did not invert relay 1");

    a_hold_cmd: assert property (@(posedge clk) disable iff (sys_rst)           //RQ3
        out_wr && avs_byteenable[2] && !usb_suspend && avs_writedata[19:16] >= 4'h3
        |=> $stable(relay_on[2]))
        else $error("hold changed relay 2");

    a_standby_off: assert property (@(posedge clk) disable iff (sys_rst)        //RQ19
        entering && !out_wr && out_cmd[3][7:4] == 4'h0 |=> !relay_on[3])
        else $error("standby nibble not applied");

    a_state_bytes: assert property (@(posedge clk) disable iff (sys_rst)        //RQ5
        acc_rd && avs_address == `OFS_IN_STATES
        |-> avs_readdata[7:1] == 7'h0 && avs_readdata[31:25] == 7'h0)
        else $error("state byte not 0 or 1");

    a_frame_step: assert property (@(posedge clk) disable iff (sys_rst)         //RQ4
        ms_tick |-> frame == $past(frame) + 16'h1)
        else $error("frame number did not advance");

    a_sample_report: assert property (@(posedge clk) disable iff (sys_rst)      //RQ13
        sample_tick && cfg[0].report_trigger_mode == TRIG_AFTER_SAMPLE
        |=> report_strobe && in_state == $past(sampled))
        else $error("no report after sample");

    a_sample_floor: assert property (@(posedge clk) disable iff (sys_rst)       //RQ18
        cfg[0].state_sampling_interval >= `MIN_SAMPLE
        && cfg[1].state_sampling_interval >= `MIN_SAMPLE)
        else $error("sampling interval too low");

    a_report_floor: assert property (@(posedge clk) disable iff (sys_rst)       //RQ17
        cfg[0].in_report_interval >= `MIN_IN_INTERVAL)
        else $error("IN report interval too low");

    a_get_header: assert property (@(posedge clk) disable iff (sys_rst)         //RQ21
        feat_go && feat_buf[0] == `FEAT_GET
        |=> feat_buf[2] == $past(feat_buf[2]) && feat_buf[3] == $past(feat_buf[3]))
        else $error("get altered the header");

    a_default_mode: assert property (@(posedge clk)                             //RQ9
        $fell(sys_rst) |-> cfg[0].report_trigger_mode == TRIG_FIXED_RATE)
        else $error("trigger mode not fixed after reset");

endmodule : usb_relay_report_interpreter

// [testbench/usb_host_model.sv]
/* Host firmware model: moves OUT and feature reports over Avalon-MM.
   Assumes a slave that answers by dropping waitrequest. */
`timescale 1ns/1ps
`include "relay_regs.svh"
module usb_host_model (
    // Clock.
    input  wire logic        clk,
    // Avalon-MM master.
    output logic      [7:0]  avs_address,
    output logic             avs_read,
    output logic             avs_write,
    output logic      [31:0] avs_writedata,
    output logic      [3:0]  avs_byteenable,
    input  wire logic        avs_waitrequest
);
    initial begin
        avs_address    = 8'h00;
        avs_read       = 1'b0;
        avs_write      = 1'b0;
        avs_writedata  = 32'h0;
        avs_byteenable = 4'hf;
    end

    // Released write data is inverted so stale data cannot pass.
    task automatic access(input logic [7:0] a, input logic wr, input logic [31:0] d);
        @(posedge clk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= ~wr;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        avs_write     <= 1'b0;
        avs_read      <= 1'b0;
        avs_writedata <= ~d;
    endtask : access

    task automatic send_out(input logic [31:0] cmds);
        access(`OFS_OUT_REPORT, 1'b1, cmds);
    endtask : send_out

    task automatic send_feature(input logic [7:0] dir, input logic [7:0] tgt,
                                input logic [7:0] code, input logic [7:0] sub,
                                input logic [15:0] val);
        access(`OFS_FEAT_BUF, 1'b1, {sub, code, tgt, dir});
        access(`OFS_FEAT_BUF + 8'h04, 1'b1, {8'h00, val, 8'h00});
        for (int i = 8; i < `FEAT_BYTES; i += 4) begin
            access(`OFS_FEAT_BUF + 8'(i), 1'b1, 32'h0);
        end
        access(`OFS_FEAT_CTRL, 1'b1, 32'h1);
    endtask : send_feature
endmodule : usb_host_model

// [testbench/usb_relay_report_interpreter_tb_top.sv]
/* Self-checking bench of the relay report interpreter.
   Assumes the host model drives the bus; usb_suspend comes from here. */
`timescale 1ns/1ps
`include "relay_regs.svh"
module usb_relay_report_interpreter_tb_top;
    localparam int          CYC = 10;
    localparam logic [31:0] M1  = 32'hffff;
    localparam logic [31:0] M2  = 32'h00ff_ffff;
    typedef struct {
        logic [31:0] exp;
        logic [31:0] mask;
        string       name;
    } note_t;

    logic        clk;
    logic        sys_rst;
    logic [7:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        usb_suspend;
    logic [3:0]  relay_on;
    logic        indicator_light;
    logic        report_strobe;
    logic [3:0]  relays;
    logic [31:0] cmd;
    int          gap;
    int          miscompares;
    int          n_tests;
    note_t       notes[$];

    usb_relay_report_interpreter #(.CYC_PER_MS(CYC)) i_dut (
        .clk(clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .usb_suspend(usb_suspend), .relay_on(relay_on),
        .indicator_light(indicator_light), .report_strobe(report_strobe));

    usb_host_model i_host (
        .clk(clk), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_waitrequest(avs_waitrequest));

    always #2.5 clk = ~clk;

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // Read data is judged where waitrequest is sampled low.
    always @(posedge clk) begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && notes.size() > 0) begin
            chk(notes[0].name, notes[0].exp & notes[0].mask, avs_readdata & notes[0].mask);
            void'(notes.pop_front());
        end
    end

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] mask,
                          input string name);
        notes.push_back('{exp, mask, name});
        i_host.access(a, 1'b0, 32'h0);
    endtask : rd_chk

    function automatic logic [3:0] apply(input logic [3:0] cur, input logic [31:0] c, input int hi);
        logic [3:0] nxt;
        for (int k = 0; k < 4; k++) begin
            case (c[8*k + 4*hi +: 4])
                4'h0: nxt[k] = 1'b0;
                4'h1: nxt[k] = 1'b1;
                4'h2: nxt[k] = ~cur[k];
                default: nxt[k] = cur[k];
            endcase
        end
        return nxt;
    endfunction : apply

    task automatic get_chk(input logic [7:0] tgt, input logic [7:0] code, input logic [7:0] sub,
                           input logic [15:0] exp, input logic [31:0] mask);
        i_host.send_feature(`FEAT_GET, tgt, code, sub, 16'h0000);
        rd_chk(`OFS_FEAT_BUF, {sub, code, tgt, `FEAT_GET}, 32'hffff_ffff, "echoed header");
        rd_chk(`OFS_FEAT_BUF + 8'h04, {8'h00, exp, 8'h00}, mask, "setting value");
    endtask : get_chk

    task automatic wait_strobe();
        gap = 0;
        do begin
            @(posedge clk);
            gap++;
        end while (report_strobe !== 1'b1 && gap < 20000);
    endtask : wait_strobe

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        repeat (60000) @(posedge clk);
        miscompares++;
        tally_and_finish();
    end

    initial begin
        void'($urandom(78852));
        clk = 1'b0;
        sys_rst = 1'b1;
        usb_suspend = 1'b0;
        relays = 4'h0;
        miscompares = 0;
        n_tests = 0;
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        rd_chk(`OFS_STATUS, 32'h0, 32'hf06, "status after reset");
        for (int i = 0; i < 13; i++) begin
            cmd = (i == 0) ? 32'h0f02_0100 : ($urandom() & 32'h3333_3333);
            relays = apply(relays, cmd, 0);
            i_host.send_out(cmd);
            rd_chk(`OFS_STATUS, {20'h0, relays, 8'h00}, 32'hf00, "live relays");
            chk("relay pins", 32'(relays), 32'(relay_on));
        end
        wait_strobe();
        rd_chk(`OFS_IN_STATES, {7'h0, relays[3], 7'h0, relays[2], 7'h0, relays[1], 7'h0,
               relays[0]}, 32'hffff_ffff, "report states");
        // Standby nibbles switch all relays off, relay 3 by toggling.
        cmd = 32'h2101_0101;
        i_host.send_out(cmd);
        relays = apply(apply(relays, cmd, 0), cmd, 1);
        usb_suspend <= 1'b1;
        rd_chk(`OFS_STATUS, {20'h0, relays, 8'h02}, 32'hf02, "standby relays");
        usb_suspend <= 1'b0;
        rd_chk(`OFS_STATUS, {20'h0, relays, 8'h00}, 32'hf02, "after standby");
        for (int m = 0; m < 5; m++) begin
            i_host.send_feature(`FEAT_SET, `TGT_RAM, `FC_MODE, `SUB_LED_MODE, 16'(m));
            get_chk(`TGT_RAM, `FC_MODE, `SUB_LED_MODE, 16'(m), M1);
            if (m < 3) begin
                i_host.send_feature(`FEAT_SET, `TGT_RAM, `FC_MODE, `SUB_REPORT_MODE, 16'(m));
                get_chk(`TGT_RAM, `FC_MODE, `SUB_REPORT_MODE, 16'(m), M1);
            end
        end
        i_host.send_feature(`FEAT_SET, `TGT_RAM, `FC_MODE, `SUB_LED_MODE, 16'h0001);
        repeat (`LED_STEP_MS * CYC + 20) @(posedge clk);
        chk("indicator light", 32'h1, {31'h0, indicator_light});
        i_host.send_feature(`FEAT_SET, `TGT_RAM, `FC_RATE, `SUB_IN_INTERVAL, 16'h1234);
        get_chk(`TGT_RAM, `FC_RATE, `SUB_IN_INTERVAL, 16'h1234, M2);
        i_host.send_feature(`FEAT_SET, `TGT_RAM, `FC_RATE, `SUB_IN_INTERVAL, 16'h0000);
        get_chk(`TGT_RAM, `FC_RATE, `SUB_IN_INTERVAL, 16'h0001, M2);
        wait_strobe();
        wait_strobe();
        chk("fixed report gap", CYC, gap);
        i_host.send_feature(`FEAT_SET, `TGT_RAM, `FC_RATE, `SUB_SAMPLE, 16'h0003);
        get_chk(`TGT_RAM, `FC_RATE, `SUB_SAMPLE, 16'h0004, M2);
        i_host.send_feature(`FEAT_SET, `TGT_RAM, `FC_RATE, `SUB_SAMPLE, 16'h0006);
        i_host.send_feature(`FEAT_SET, `TGT_RAM, `FC_MODE, `SUB_REPORT_MODE, 16'h0000);
        wait_strobe();
        wait_strobe();
        chk("sample report gap", 6 * CYC, gap);
        i_host.send_feature(`FEAT_SET, `TGT_FLASH, `FC_RATE, `SUB_SAMPLE, 16'h00aa);
        get_chk(`TGT_RAM, `FC_RATE, `SUB_SAMPLE, 16'h0006, M2);
        get_chk(`TGT_FLASH, `FC_RATE, `SUB_SAMPLE, 16'h00aa, M2);
        i_host.send_feature(8'h02, `TGT_RAM, `FC_MODE, `SUB_LED_MODE, 16'h0000);
        rd_chk(`OFS_STATUS, 32'h4, 32'h4, "bad direction");
        for (int s = 0; s < 6; s++) begin
            i_host.send_feature(`FEAT_SET, `TGT_RAM, `FC_LABEL, 8'(s), {8'h30 + 8'(s), 8'h41});
            get_chk(`TGT_RAM, `FC_LABEL, 8'(s), {8'h30 + 8'(s), 8'h41}, M2);
        end
        rd_chk(`OFS_STATUS, 32'h0, 32'h4, "good command");
        i_host.send_feature(`FEAT_SET, `TGT_RAM, `FC_MODE, `SUB_LED_MODE, 16'h0005);
        get_chk(`TGT_RAM, `FC_MODE, `SUB_LED_MODE, 16'h0001, M1);
        @(posedge clk);
        tally_and_finish();
    end
endmodule : usb_relay_report_interpreter_tb_top
